// file: design/jtp_cfg.svh
// Purpose: Constants for the serial test port block.
// Assumes: Single system clock of 10 MHz.
// Notes: Definitions only.
`ifndef JTP_CFG_SVH
`define JTP_CFG_SVH
`define JTP_CLK_PERIOD_NS 100
`define JTP_IR_W 4
`define JTP_DR_W 32
`define JTP_IR_RESET 4'h1
`define JTP_IR_BYPASS 4'hf
`define JTP_IR_IDCODE 4'h1
`define JTP_IR_USER 4'h8
`define JTP_IDCODE_VAL 32'h1234_5671 // Arbitrary value, names no real maker or part
`define JTP_FIFO_DEPTH 4
`define JTP_BOOT_W 4
`endif

// file: design/jtp_fifo.sv
// Purpose: Small flip-flop FIFO with valid/ready on both sides.
// Assumes: Same clock on both sides.
// Notes: Full and empty are exact; no write while full, no read while empty.
`timescale 1ns/1ps
module jtp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write, addressed by index
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wr_r] <= in_data;
  end

  // Pointers wrap at DEPTH so non-power-of-two depths work
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      if (pop)
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // jtp_fifo

// file: design/jtp_pkg.sv
// Purpose: Types for the serial test port block.
// Assumes: Constants come from jtp_cfg.svh.
// Notes: Nothing here is imported; use jtp_pkg::name.
package jtp_pkg;
  // Test controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
    ST_UP_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UP_IR = 16'h8000
  } jtp_state_t;

  // Debugger pins as seen by the device
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic ctrl_sel;
  } jtp_pins_t;
endpackage

// file: design/jtp_port.sv
// Purpose: Serial test access port with return clock and boot strap capture.
// Assumes: Debugger pins are asynchronous to clk and pass two flip-flops;
//          test clock is far slower than clk (800 ns vs 100 ns).
// Notes: Completed user data-register words leave through a 4-word FIFO.
`timescale 1ns/1ps
`include "jtp_cfg.svh"
module jtp_port #(
  parameter int DR_W = `JTP_DR_W,
  parameter int FIFO_DEPTH = `JTP_FIFO_DEPTH,
  parameter logic [31:0] IDCODE = `JTP_IDCODE_VAL // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire jtp_pkg::jtp_pins_t pins,
  output logic tdo,
  output logic tdo_oe_n,
  output logic returned_test_clock,
  output logic returned_test_clock_oe_n,
  input wire logic wire_bus_sel,
  input wire logic [`JTP_BOOT_W-1:0] boot_pins,
  output logic [`JTP_BOOT_W-1:0] boot_mode,
  input wire logic standby_voltage_request,
  output logic [1:0] boot_hs_out,
  output logic [1:0] boot_hs_oe_n,
  output logic test_ctrl_dbg,
  output logic [DR_W-1:0] word_data,
  output logic word_valid,
  input wire logic word_ready
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [`JTP_BOOT_W-1:0] b1_r;
  logic [`JTP_BOOT_W-1:0] b2_r;
  logic tck_d_r;
  logic trst_d_r;
  logic tck_rise;
  logic tck_fall;
  logic trst_n_s;
  logic trst_rel;

  // Two stages for every debugger and boot pin; only stage two is read by logic
  always_ff @(posedge clk)
  begin
    s1_r <= {pins.tck, pins.tms, pins.tdi, pins.trst_n, pins.ctrl_sel};
    s2_r <= s1_r;
    b1_r <= boot_pins;
    b2_r <= b1_r;
  end

  // Edge history of synchronised test clock and test reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tck_d_r <= 1'b0;
      trst_d_r <= 1'b1; // Idle level, so leaving reset is not taken as a release
    end
    else
    begin
      tck_d_r <= s2_r[4];
      trst_d_r <= s2_r[1];
    end
  end

  assign trst_n_s = s2_r[1];
  assign tck_rise = s2_r[4] && !tck_d_r;
  assign tck_fall = !s2_r[4] && tck_d_r;
  assign trst_rel = trst_n_s && !trst_d_r;

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  logic ctrl_sel_r;
  logic boot_taken_r;
  logic [`JTP_BOOT_W-1:0] boot_r;

  // Latch select strap
  // Held in reset high so a debugger gets the normal controller by default
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_sel_r <= 1'b1;
    else if (trst_rel)
      ctrl_sel_r <= s2_r[0];
  end
  assign test_ctrl_dbg = ctrl_sel_r;

  // Boot strap sample
  // Taken on the first edge after release, since a port may not load under async reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      boot_taken_r <= 1'b0;
      boot_r <= '0;
    end
    else if (!boot_taken_r)
    begin
      boot_taken_r <= 1'b1;
      boot_r <= b2_r;
    end
  end
  assign boot_mode = boot_r;

  logic hs_r;

  // Standby handshake
  // Registered so the handshake pin comes straight from a flip-flop
  always_ff @(posedge clk)
  begin
    if (rst)
      hs_r <= 1'b0;
    else
      hs_r <= standby_voltage_request;
  end

  // Low boot pins are released during sampling, then drive the handshake
  assign boot_hs_out = {1'b0, hs_r};
  assign boot_hs_oe_n = boot_taken_r ? 2'b00 : 2'b11;

  // ----------------------------------------
  // Test controller
  // ----------------------------------------
  jtp_pkg::jtp_state_t st_r;
  jtp_pkg::jtp_state_t st_nxt;
  logic tms;
  assign tms = s2_r[3];

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      jtp_pkg::ST_RESET: st_nxt = tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_IDLE: st_nxt = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SEL_DR: st_nxt = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
      jtp_pkg::ST_CAP_DR: st_nxt = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_SH_DR: st_nxt = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_EX1_DR: st_nxt = tms ? jtp_pkg::ST_UP_DR : jtp_pkg::ST_PA_DR;
      jtp_pkg::ST_PA_DR: st_nxt = tms ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PA_DR;
      jtp_pkg::ST_EX2_DR: st_nxt = tms ? jtp_pkg::ST_UP_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_UP_DR: st_nxt = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SEL_IR: st_nxt = tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAP_IR;
      jtp_pkg::ST_CAP_IR: st_nxt = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_SH_IR: st_nxt = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_EX1_IR: st_nxt = tms ? jtp_pkg::ST_UP_IR : jtp_pkg::ST_PA_IR;
      jtp_pkg::ST_PA_IR: st_nxt = tms ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PA_IR;
      jtp_pkg::ST_EX2_IR: st_nxt = tms ? jtp_pkg::ST_UP_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_UP_IR: st_nxt = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      default: st_nxt = jtp_pkg::ST_RESET;
    endcase
  end

  // Test reset overrides
  // Acts on the synchronised level at every clk edge, no test clock needed
  // Test clock rise steps state; mode select picks the next one
  always_ff @(posedge clk)
  begin
    if (rst || !trst_n_s)
      st_r <= jtp_pkg::ST_RESET;
    else if (tck_rise)
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // Instruction and data shift paths
  // ----------------------------------------
  logic [`JTP_IR_W-1:0] ir_sh_r;
  logic [`JTP_IR_W-1:0] ir_r;
  logic [DR_W-1:0] dr_sh_r;
  logic byp_r;
  logic tdi;
  logic push;
  logic dr_serial;
  logic byp_sel;
  assign tdi = s2_r[2];
  assign byp_sel = (ir_r == `JTP_IR_BYPASS) || !ctrl_sel_r;

  always_ff @(posedge clk)
  begin
    if (rst || !trst_n_s)
    begin
      ir_sh_r <= '0;
      ir_r <= `JTP_IR_RESET;
      dr_sh_r <= '0;
      byp_r <= 1'b0;
    end
    else if (st_r == jtp_pkg::ST_RESET)
      ir_r <= `JTP_IR_RESET;
    else if (tck_rise)
    begin
      if (st_r == jtp_pkg::ST_CAP_IR)
        ir_sh_r <= `JTP_IR_W'(1);
      if (st_r == jtp_pkg::ST_SH_IR)
        ir_sh_r <= {tdi, ir_sh_r[`JTP_IR_W-1:1]};
      if (st_r == jtp_pkg::ST_UP_IR)
        ir_r <= ir_sh_r;
      if (st_r == jtp_pkg::ST_CAP_DR)
      begin
        dr_sh_r <= (ir_r == `JTP_IR_IDCODE) ? DR_W'(IDCODE) : '0;
        byp_r <= 1'b0;
      end
      if (st_r == jtp_pkg::ST_SH_DR)
      begin
        dr_sh_r <= {tdi, dr_sh_r[DR_W-1:1]};
        byp_r <= tdi;
      end
    end
  end

  // User words leave on update; a full FIFO drops the word rather than stall the probe
  assign push = tck_rise && (st_r == jtp_pkg::ST_UP_DR) && (ir_r == `JTP_IR_USER)
    && ctrl_sel_r;

  jtp_fifo #(
    .WIDTH(DR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(),
    .in_data(dr_sh_r),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  logic tdo_r;
  logic tdo_en_r;
  assign dr_serial = byp_sel ? byp_r : dr_sh_r[0];

  always_ff @(posedge clk)
  begin
    if (rst || !trst_n_s)
    begin
      tdo_r <= 1'b0;
      tdo_en_r <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_en_r <= (st_r == jtp_pkg::ST_SH_DR) || (st_r == jtp_pkg::ST_SH_IR);
      tdo_r <= (st_r == jtp_pkg::ST_SH_IR) ? ir_sh_r[0] : dr_serial;
    end
  end
  assign tdo = tdo_r;
  assign tdo_oe_n = !tdo_en_r;

  // ----------------------------------------
  // Return clock
  // ----------------------------------------
  logic returned_test_clock_r;

  // Echo synchronised clock
  // Echo lags by the sync delay plus two stages; the probe model paces on fixed clk counts, not on this echo
  always_ff @(posedge clk)
  begin
    if (rst)
      returned_test_clock_r <= 1'b0;
    else
      returned_test_clock_r <= tck_d_r;
  end
  assign returned_test_clock = returned_test_clock_r;
  assign returned_test_clock_oe_n = wire_bus_sel;
endmodule // jtp_port

// file: tb/jtp_port_monitor.sv
// Purpose: Concurrent checks on the test port pins.
// Assumes: Pins reach clk through two sync flops.
// Notes: Bound to jtp_port from tb_top.
`timescale 1ns/1ps
module jtp_port_monitor #(
  parameter int DR_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire jtp_pkg::jtp_pins_t pins,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic returned_test_clock,
  input wire logic returned_test_clock_oe_n,
  input wire logic wire_bus_sel,
  input wire logic [3:0] boot_mode,
  input wire logic standby_voltage_request,
  input wire logic [1:0] boot_hs_out,
  input wire logic test_ctrl_dbg,
  input wire logic [DR_W-1:0] word_data,
  input wire logic word_valid,
  input wire logic word_ready
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Strap must hold still while the latch settles
  sequence trst_up_s;
    $rose(pins.trst_n) ##1 $stable(pins.ctrl_sel) [*6];
  endsequence
  sequence quiet_s;
    !rst [*5];
  endsequence
  returned_test_clock_rise_a:
    assert property ($rose(pins.tck) |-> ##[1:6] returned_test_clock) else $error("returned_test_clock rise");
  returned_test_clock_fall_a:
    assert property ($fell(pins.tck) |-> ##[1:6] !returned_test_clock) else $error("returned_test_clock fall");
  // Sync delay puts the causing tck fall two samples back
  tdo_edge_a:
    assert property ($changed(tdo) |-> $past(pins.tck, 2) == 1'b0) else $error("tdo edge");
  trst_quiet_a:
    assert property (!pins.trst_n [*5] |-> tdo_oe_n) else $error("tdo driven in reset");
  sel_latch_a:
    assert property (trst_up_s |-> test_ctrl_dbg == pins.ctrl_sel) else $error("strap latch");
  returned_test_clock_share_a:
    assert property (returned_test_clock_oe_n == wire_bus_sel) else $error("returned_test_clock enable");
  boot_hold_a:
    assert property (quiet_s |=> $stable(boot_mode)) else $error("boot mode moved");
  hs_follow_a:
    assert property ($stable(standby_voltage_request) [*4] |->
      boot_hs_out == {1'b0, standby_voltage_request}) else $error("standby handshake");
  word_hold_a:
    assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
      else $error("word dropped");
endmodule // jtp_port_monitor

// file: tb/jtp_probe.sv
// Purpose: Debugger probe model driving the test port pins.
// Assumes: Test clock of 800 ns, four clk per half.
// Notes: Test clock parks low between scans.
`timescale 1ns/1ps
module jtp_probe (
  input wire logic clk,
  input wire logic tdo,
  output jtp_pkg::jtp_pins_t pins
);
  initial pins = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One test clock; serial out read after the rise, where it stands
  task automatic step(input logic tms, input logic tdi, output logic so);
    pins = '{1'b0, tms, tdi, pins.trst_n, pins.ctrl_sel};
    cyc(4);
    pins.tck = 1'b1;
    cyc(1);
    so = tdo;
    cyc(3);
  endtask
  task automatic go_idle();
    logic so;
    step(1'b0, 1'b0, so);
    pins.tck = 1'b0;
    cyc(4);
  endtask
  task automatic tap_reset();
    logic so;
    for (int i = 0; i < 5; i++)
      step(1'b1, 1'b0, so);
    go_idle();
  endtask
  // Strap may only move with test reset low
  task automatic trst_pulse(input logic sel);
    pins.trst_n = 1'b0;
    pins.ctrl_sel = sel;
    cyc(6);
    pins.trst_n = 1'b1;
    cyc(8);
    go_idle();
  endtask
  // From idle: select, capture, shift n bits LSB first, update, idle
  task automatic scan(input logic ir, input logic [31:0] d, input int n, output logic [31:0] q);
    logic so;
    q = '0;
    step(1'b1, 1'b0, so);
    if (ir)
      step(1'b1, 1'b0, so);
    step(1'b0, 1'b0, so);
    step(1'b0, 1'b0, so);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, d[i], so);
      q[i] = so;
    end
    step(1'b1, 1'b0, so);
    go_idle();
  endtask
endmodule // jtp_probe

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the serial test port.
// Assumes: Probe model drives the debugger pins.
// Notes: Every test ends through summarize.
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] ID = 32'h0c0f_fee1; // Arbitrary code
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wire_bus_sel = 1'b0;
  logic [3:0] boot_pins = 4'ha;
  logic standby_voltage_request = 1'b0;
  logic word_ready = 1'b0;
  logic tdo, tdo_oe_n, returned_test_clock, returned_test_clock_oe_n, test_ctrl_dbg, word_valid;
  logic [3:0] boot_mode;
  logic [1:0] boot_hs_out, boot_hs_oe_n;
  logic [31:0] word_data, q;
  jtp_pkg::jtp_pins_t pins;
  int errors = 0;
  int checked = 0;
  // Clock
  always #50 clk = ~clk;
  jtp_probe u_probe (.clk(clk), .tdo(tdo), .pins(pins));
  jtp_port #(.IDCODE(ID)) u_dut (.clk, .rst, .pins, .tdo, .tdo_oe_n, .returned_test_clock,
    .returned_test_clock_oe_n, .wire_bus_sel, .boot_pins, .boot_mode, .standby_voltage_request,
    .boot_hs_out, .boot_hs_oe_n, .test_ctrl_dbg, .word_data, .word_valid, .word_ready);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Boot straps taken once; later boot pin moves must not leak through
  task automatic t_reset();
    check(boot_mode, 4'ha);
    check(test_ctrl_dbg, 1'b1);
    check(word_valid, 1'b0);
    boot_pins = 4'h5;
    cyc(4);
    check(boot_mode, 4'ha);
  endtask
  task automatic t_pins();
    wire_bus_sel = 1'b1;
    cyc(1);
    check(returned_test_clock_oe_n, 1'b1);
    wire_bus_sel = 1'b0;
    standby_voltage_request = 1'b1;
    cyc(4);
    check(returned_test_clock_oe_n, 1'b0);
    check(boot_hs_out, 2'b01);
    check(boot_hs_oe_n, 2'b00);
    standby_voltage_request = 1'b0;
    cyc(4);
    check(boot_hs_out, 2'b00);
  endtask
  // Identity after scan reset, then after test reset, each with bypass loaded
  task automatic t_ident();
    u_probe.tap_reset();
    u_probe.scan(1'b1, 32'hf, 4, q);
    u_probe.tap_reset();
    u_probe.scan(1'b0, 32'h0, 32, q);
    check(q, ID);
    u_probe.scan(1'b1, 32'hf, 4, q);
    u_probe.trst_pulse(1'b1);
    u_probe.scan(1'b0, 32'h0, 32, q);
    check(q, ID);
  endtask
  // Bypass delays the stream by one bit
  task automatic t_bypass();
    u_probe.scan(1'b1, 32'hf, 4, q);
    u_probe.scan(1'b0, 32'h8000_00b5, 32, q);
    check(q, 32'h0000_016a);
    check(tdo_oe_n, 1'b1);
  endtask
  // Low strap forces bypass until the next test reset
  task automatic t_select();
    u_probe.trst_pulse(1'b0);
    check(test_ctrl_dbg, 1'b0);
    u_probe.scan(1'b0, 32'h0000_0003, 32, q);
    check(q, 32'h0000_0006);
    u_probe.trst_pulse(1'b1);
    check(test_ctrl_dbg, 1'b1);
  endtask
  // Five words into a stalled 4-word buffer: the fifth is dropped
  task automatic t_fifo();
    u_probe.scan(1'b1, 32'h8, 4, q);
    for (int k = 0; k < 5; k++)
      u_probe.scan(1'b0, 32'ha500_0000 + 32'(k), 32, q);
    check(word_valid, 1'b1);
    word_ready = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      check(word_data, 32'ha500_0000 + 32'(k));
      cyc(1);
    end
    word_ready = 1'b0;
    check(word_valid, 1'b0);
  endtask
  initial
  begin
    cyc(12);
    rst = 1'b0;
    cyc(5);
    t_reset();
    t_pins();
    t_ident();
    t_bypass();
    t_select();
    t_fifo();
    summarize();
  end
  // Watchdog: the run needs about 0.33 ms
  initial
  begin
    #2_000_000;
    errors++;
    summarize();
  end
endmodule // tb_top
bind jtp_port jtp_port_monitor #(.DR_W(DR_W)) u_mon (.clk, .rst, .pins, .tdo, .tdo_oe_n,
  .returned_test_clock, .returned_test_clock_oe_n, .wire_bus_sel, .boot_mode, .standby_voltage_request,
  .boot_hs_out, .test_ctrl_dbg, .word_data, .word_valid, .word_ready);
